// *** verilog/drive_status.sv ***
`timescale 1ns/1ps
module drive_status #(
    parameter logic [3:0] ID_CODE = drive_status_pkg::ID_CODE_DEFAULT,
    parameter logic [3:0] SECTOR_CFG = drive_status_pkg::CFG_64_SECTORS,
    parameter int TRACE_DEPTH = drive_status_pkg::TRACE_DEPTH
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // commands decoded from the event and extended command bytes
    input wire logic fault_reset_cmd_in,
    input wire logic return_track_zero_cmd_in,
    input wire logic seek_cmd_in,
    input wire logic [7:0] seek_cyl_in,
    input wire logic head_sel_cmd_in,
    input wire logic [7:0] head_num_in,
    input wire logic event_done_in,
    input wire logic zero_event_in,
    input wire logic send_identity_bit_in,
    input wire logic send_trace_in,
    input wire logic send_detail_in,
    input wire logic auto_status_mode_in,
    // drive condition from servo and firmware logic
    input wire logic fault_detect_in,
    input wire logic track_lock_lost_in,
    input wire logic on_track_in,
    input wire logic trace_push_in,
    input wire logic [7:0] firmware_trace_code,
    // panel and sensor pins
    input wire logic cart_tab_in,
    input wire logic fixed_switch_in,
    input wire logic panel_protect_switch_in,
    input wire logic spindle_speed_ok_in,
    input wire logic spindle_stopped_in,
    input wire logic stop_condition_in,
    input wire logic heads_on_tracks_in,
    input wire logic purge_done_in,
    input wire logic drive_selected_in,
    // register read port
    input wire logic rd_start_in,
    input wire logic [2:0] rd_addr_in,
    output logic [7:0] rd_data_out,
    // transfer request toward the adapter
    output logic xfer_req_out,
    output logic [2:0] xfer_addr_out,
    input wire logic xfer_ack_in,
    output logic irq_out,
    // drive control
    output logic halt_out,
    output logic write_inhibit_out,
    output logic head_load_start_out,
    output logic positioner_move_out,
    output logic [7:0] target_cyl_out,
    output logic [1:0] cur_head_out
);
    initial
    begin
        if (TRACE_DEPTH != drive_status_pkg::TRACE_DEPTH)
            $error("trace depth other than sixteen is not supported");
    end

    // ==========================================
    // pin synchronisers
    localparam int NPIN = 9;
    logic [NPIN-1:0] pin_meta_reg;
    logic [NPIN-1:0] pin_sync_reg;
    logic panel_prev_reg;
    logic cart_tab, fixed_sw, panel_sw, speed_ok, stopped, stop_sw;
    logic heads_on, purge_done, selected;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end
        else
        begin
            pin_meta_reg <= {drive_selected_in, purge_done_in, heads_on_tracks_in,
                             stop_condition_in, spindle_stopped_in, spindle_speed_ok_in,
                             panel_protect_switch_in, fixed_switch_in, cart_tab_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {selected, purge_done, heads_on, stop_sw, stopped, speed_ok,
            panel_sw, fixed_sw, cart_tab} = pin_sync_reg;

    // the switch level is unknown at reset, so its first sample is taken after release
    logic panel_seen_reg;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            panel_prev_reg <= 1'b0;
            panel_seen_reg <= 1'b0;
        end
        else
        begin
            panel_prev_reg <= panel_sw;
            panel_seen_reg <= 1'b1;
        end
    end

    // ==========================================
    // fault and command gating
    logic fault_reg;
    logic seek_err_reg;
    logic panel_toggle;
    logic fault_reset;
    logic cmd_blocked;
    logic bad_cyl;
    logic bad_head;
    logic valid_seek;
    logic valid_head;

    assign panel_toggle = panel_seen_reg && (panel_sw != panel_prev_reg);
    assign fault_reset = fault_reset_cmd_in || (panel_toggle && fault_reg);
    assign cmd_blocked = fault_reg || seek_err_reg;
    assign bad_cyl = seek_cmd_in && !cmd_blocked && seek_cyl_in > drive_status_pkg::MAX_CYLINDER;
    assign bad_head = head_sel_cmd_in && !cmd_blocked && head_num_in > drive_status_pkg::MAX_HEAD;
    assign valid_head = head_sel_cmd_in && !cmd_blocked && !bad_head;
    assign valid_seek = seek_cmd_in && !cmd_blocked && !bad_cyl && !bad_head;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            fault_reg <= 1'b0;
        else if (fault_detect_in)
            fault_reg <= 1'b1;
        else if (fault_reset)
            fault_reg <= 1'b0;
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            seek_err_reg <= 1'b0;
        else if (track_lock_lost_in || bad_cyl || bad_head)
            seek_err_reg <= 1'b1;
        else if (return_track_zero_cmd_in)
            seek_err_reg <= 1'b0;
    end

    // ==========================================
    // positioner, head and on-cylinder
    logic on_cyl_reg;
    logic [1:0] head_reg;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            on_cyl_reg <= 1'b0;
        else if (track_lock_lost_in)
            on_cyl_reg <= 1'b0;
        else if (on_track_in)
            on_cyl_reg <= 1'b1;
        else if (valid_seek)
            on_cyl_reg <= 1'b0;
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            head_reg <= drive_status_pkg::HEAD_POWER_UP;
        else if (valid_head)
            head_reg <= head_num_in[1:0];
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            positioner_move_out <= 1'b0;
            target_cyl_out <= drive_status_pkg::BYTE_ZERO;
        end
        else
        begin
            positioner_move_out <= valid_seek;
            if (valid_seek)
                target_cyl_out <= seek_cyl_in;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            head_load_start_out <= 1'b0;
        else
            head_load_start_out <= fault_reset && fault_reg && !fault_detect_in
                                   && purge_done;
    end

    // ==========================================
    // write protection and status bytes
    logic volume_protect;
    logic [7:0] main_byte;
    logic [7:0] detail_byte;
    logic [7:0] identity_byte;

    assign volume_protect = head_reg[1] ? fixed_sw : cart_tab;
    assign halt_out = fault_reg;
    assign write_inhibit_out = fault_reg || volume_protect || positioner_move_out;
    assign cur_head_out = head_reg;

    always_comb
    begin
        main_byte = drive_status_pkg::BYTE_ZERO;
        main_byte[drive_status_pkg::MAIN_FAULT_BIT] = fault_reg;
        main_byte[drive_status_pkg::MAIN_SEEK_ERR_BIT] = seek_err_reg;
        main_byte[drive_status_pkg::MAIN_UNIT_READY_BIT] = selected && speed_ok
                                                           && heads_on;
        main_byte[drive_status_pkg::MAIN_ON_CYL_BIT] = on_cyl_reg;
        main_byte[drive_status_pkg::MAIN_WP_BIT] = volume_protect;
        main_byte[drive_status_pkg::MAIN_PURGE_BIT] = purge_done;
    end

    always_comb
    begin
        detail_byte = drive_status_pkg::BYTE_ZERO;
        detail_byte[drive_status_pkg::DETAIL_CART_TAB_BIT] = cart_tab;
        detail_byte[drive_status_pkg::DETAIL_FIXED_SW_BIT] = fixed_sw;
        detail_byte[drive_status_pkg::DETAIL_SPEED_OK_BIT] = speed_ok;
        detail_byte[drive_status_pkg::DETAIL_STOPPED_BIT] = stopped;
        detail_byte[drive_status_pkg::DETAIL_STOP_SW_BIT] = stop_sw;
    end

    assign identity_byte = {ID_CODE, SECTOR_CFG};

    // ==========================================
    // trace code store
    trace_if #(.WIDTH(8)) tr ();
    logic trace_read;

    assign trace_read = rd_start_in && rd_addr_in == drive_status_pkg::ADDR_TRACE;
    assign tr.push = trace_push_in;
    assign tr.push_data = firmware_trace_code;
    assign tr.pop = trace_read && !fault_reset;
    assign tr.clear = fault_reset;

    trace_store #(.DEPTH(TRACE_DEPTH), .WIDTH(8)) u_trace
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .tr(tr.store)
    );

    // ==========================================
    // read snapshot
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            rd_data_out <= drive_status_pkg::BYTE_ZERO;
        else if (rd_start_in)
        begin
            case (rd_addr_in)
                drive_status_pkg::ADDR_IDENTITY: rd_data_out <= identity_byte;
                drive_status_pkg::ADDR_TRACE:
                    rd_data_out <= tr.empty ? drive_status_pkg::BYTE_ZERO
                                            : tr.head_data;
                drive_status_pkg::ADDR_DETAIL: rd_data_out <= detail_byte;
                drive_status_pkg::ADDR_MAIN: rd_data_out <= main_byte;
                default: rd_data_out <= drive_status_pkg::BYTE_ZERO;
            endcase
        end
    end

    // ==========================================
    // status delivery
    drive_status_pkg::delivery_state_type state_reg;
    logic [3:0] pend_reg;
    logic [7:0] main_prev_reg;
    logic err_rise;
    logic main_event;
    logic desel_change;
    logic [2:0] xfer_addr_reg;

    assign err_rise = (fault_detect_in && !fault_reg) || ((track_lock_lost_in || bad_cyl
                      || bad_head) && !seek_err_reg);
    assign main_event = event_done_in || err_rise;
    assign desel_change = auto_status_mode_in && !selected
                          && main_byte != main_prev_reg;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            main_prev_reg <= drive_status_pkg::BYTE_ZERO;
        else
            main_prev_reg <= main_byte;
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            pend_reg <= '0;
        else
        begin
            if (state_reg == drive_status_pkg::DLV_REQ && xfer_ack_in)
                pend_reg[xfer_addr_reg == drive_status_pkg::ADDR_IDENTITY ?
                    drive_status_pkg::PEND_IDENTITY : xfer_addr_reg ==
                    drive_status_pkg::ADDR_TRACE ? drive_status_pkg::PEND_TRACE :
                    xfer_addr_reg == drive_status_pkg::ADDR_DETAIL ?
                    drive_status_pkg::PEND_DETAIL : drive_status_pkg::PEND_MAIN] <= 1'b0;
            else if (state_reg == drive_status_pkg::DLV_IRQ && zero_event_in)
                pend_reg[drive_status_pkg::PEND_MAIN] <= 1'b0;
            if (send_identity_bit_in)
                pend_reg[drive_status_pkg::PEND_IDENTITY] <= 1'b1;
            if (send_trace_in)
                pend_reg[drive_status_pkg::PEND_TRACE] <= 1'b1;
            if (send_detail_in)
                pend_reg[drive_status_pkg::PEND_DETAIL] <= 1'b1;
            if (main_event || desel_change)
                pend_reg[drive_status_pkg::PEND_MAIN] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= drive_status_pkg::DLV_IDLE;
            xfer_addr_reg <= drive_status_pkg::ADDR_MAIN;
        end
        else
        begin
            case (state_reg)
                drive_status_pkg::DLV_IDLE:
                begin
                    if (pend_reg[drive_status_pkg::PEND_IDENTITY])
                    begin
                        xfer_addr_reg <= drive_status_pkg::ADDR_IDENTITY;
                        state_reg <= drive_status_pkg::DLV_REQ;
                    end
                    else if (pend_reg[drive_status_pkg::PEND_TRACE])
                    begin
                        xfer_addr_reg <= drive_status_pkg::ADDR_TRACE;
                        state_reg <= drive_status_pkg::DLV_REQ;
                    end
                    else if (pend_reg[drive_status_pkg::PEND_DETAIL])
                    begin
                        xfer_addr_reg <= drive_status_pkg::ADDR_DETAIL;
                        state_reg <= drive_status_pkg::DLV_REQ;
                    end
                    else if (pend_reg[drive_status_pkg::PEND_MAIN])
                    begin
                        xfer_addr_reg <= drive_status_pkg::ADDR_MAIN;
                        state_reg <= (auto_status_mode_in && selected) ?
                            drive_status_pkg::DLV_REQ : drive_status_pkg::DLV_IRQ;
                    end
                end
                drive_status_pkg::DLV_REQ:
                    if (xfer_ack_in)
                        state_reg <= drive_status_pkg::DLV_IDLE;
                drive_status_pkg::DLV_IRQ:
                    if (zero_event_in)
                        state_reg <= drive_status_pkg::DLV_IDLE;
                default: state_reg <= drive_status_pkg::DLV_IDLE;
            endcase
        end
    end

    assign xfer_req_out = (state_reg == drive_status_pkg::DLV_REQ);
    assign xfer_addr_out = xfer_addr_reg;
    assign irq_out = (state_reg == drive_status_pkg::DLV_IRQ);

    // ==========================================
    // checks
    sequence s_fault_set;
        fault_detect_in ##1 fault_reg;
    endsequence

    property p_fault_hold;
        @(posedge core_clk_in) disable iff (rst_in)
        s_fault_set ##0 !fault_reset |=> fault_reg;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");

    property p_panel_no_reset;
        @(posedge core_clk_in) disable iff (rst_in)
        fault_reg && !fault_reset_cmd_in && !fault_detect_in && !panel_toggle
        |=> fault_reg;
    endproperty
    a_panel_no_reset: assert property (p_panel_no_reset) else $error("fault lost");

    property p_reserved_zero;
        @(posedge core_clk_in) disable iff (rst_in)
        rd_start_in && rd_addr_in == drive_status_pkg::ADDR_MAIN
        |=> rd_data_out[drive_status_pkg::MAIN_RSVD1_BIT] == 1'b0
            && rd_data_out[drive_status_pkg::MAIN_RSVD3_BIT] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_seek_err_clear;
        @(posedge core_clk_in) disable iff (rst_in)
        $fell(seek_err_reg) |-> $past(return_track_zero_cmd_in);
    endproperty
    a_seek_err_clear: assert property (p_seek_err_clear) else $error("bad clear");

    property p_bad_head;
        @(posedge core_clk_in) disable iff (rst_in)
        head_sel_cmd_in && head_num_in > drive_status_pkg::MAX_HEAD
        && !fault_reg && !seek_err_reg |=> seek_err_reg;
    endproperty
    a_bad_head: assert property (p_bad_head) else $error("head error missed");

    property p_bad_cyl;
        @(posedge core_clk_in) disable iff (rst_in)
        bad_cyl && !track_lock_lost_in && !on_track_in
        |=> on_cyl_reg == $past(on_cyl_reg) && !positioner_move_out;
    endproperty
    a_bad_cyl: assert property (p_bad_cyl) else $error("invalid seek moved");

    property p_trace_clear;
        @(posedge core_clk_in) disable iff (rst_in)
        fault_reset && !trace_push_in |=> tr.empty;
    endproperty
    a_trace_clear: assert property (p_trace_clear) else $error("store not emptied");

    property p_identity_req;
        @(posedge core_clk_in) disable iff (rst_in)
        $rose(xfer_req_out) && xfer_addr_out == drive_status_pkg::ADDR_IDENTITY
        |-> $past(pend_reg[drive_status_pkg::PEND_IDENTITY]);
    endproperty
    a_identity_req: assert property (p_identity_req) else $error("unasked identity");

    property p_irq_mode;
        @(posedge core_clk_in) disable iff (rst_in)
        event_done_in && !auto_status_mode_in && state_reg == drive_status_pkg::DLV_IDLE
        && pend_reg == '0 |-> ##2 irq_out;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq not raised");

endmodule // drive_status

// *** verilog/drive_status_pkg.sv ***
package drive_status_pkg;

    // ==========================================
    // register addresses on the byte bus
    localparam logic [2:0] ADDR_IDENTITY = 3'h0;
    localparam logic [2:0] ADDR_TRACE = 3'h1;
    localparam logic [2:0] ADDR_DETAIL = 3'h2;
    localparam logic [2:0] ADDR_MAIN = 3'h7;

    // ==========================================
    // main status byte fields
    localparam int MAIN_FAULT_BIT = 0;
    localparam int MAIN_RSVD1_BIT = 1;
    localparam int MAIN_SEEK_ERR_BIT = 2;
    localparam int MAIN_RSVD3_BIT = 3;
    localparam int MAIN_UNIT_READY_BIT = 4;
    localparam int MAIN_ON_CYL_BIT = 5;
    localparam int MAIN_WP_BIT = 6;
    localparam int MAIN_PURGE_BIT = 7;

    // ==========================================
    // detailed hardware status fields
    localparam int DETAIL_CART_TAB_BIT = 0;
    localparam int DETAIL_FIXED_SW_BIT = 1;
    localparam int DETAIL_SPEED_OK_BIT = 5;
    localparam int DETAIL_STOPPED_BIT = 6;
    localparam int DETAIL_STOP_SW_BIT = 7;

    // ==========================================
    // identity byte and limits
    localparam logic [3:0] CFG_32_SECTORS = 4'h0;
    localparam logic [3:0] CFG_64_SECTORS = 4'h1;
    // arbitrary identity value
    localparam logic [3:0] ID_CODE_DEFAULT = 4'ha;
    localparam logic [7:0] MAX_CYLINDER = 8'hcd;
    localparam logic [7:0] MAX_HEAD = 8'h03;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] HEAD_POWER_UP = 2'h0;
    localparam int TRACE_DEPTH = 16;

    // ==========================================
    // pending transfer slots, main status served last
    localparam int PEND_IDENTITY = 0;
    localparam int PEND_TRACE = 1;
    localparam int PEND_DETAIL = 2;
    localparam int PEND_MAIN = 3;

    typedef enum logic [2:0]
    {
        DLV_IDLE = 3'b001,
        DLV_REQ = 3'b010,
        DLV_IRQ = 3'b100
    } delivery_state_type;

endpackage

// *** verilog/trace_if.sv ***
`timescale 1ns/1ps
interface trace_if #(parameter int WIDTH = 8);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic pop;
    logic clear;
    logic [WIDTH-1:0] head_data;
    logic empty;

    modport store (input push, input push_data, input pop, input clear,
                   output head_data, output empty);
    modport user (output push, output push_data, output pop, output clear,
                  input head_data, input empty);
endinterface

// *** verilog/trace_store.sv ***
`timescale 1ns/1ps
module trace_store #(
    parameter int DEPTH = drive_status_pkg::TRACE_DEPTH,
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // store port
    trace_if.store tr
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("trace_store depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic full;
    logic do_pop;

    assign full = (count_reg == (AW+1)'(DEPTH));
    assign do_pop = tr.pop && count_reg != '0;
    assign tr.empty = (count_reg == '0);
    assign tr.head_data = mem_reg[rd_ptr_reg];

    // ==========================================
    // wrap-around memory: a push into a full store drops the oldest code
    always_ff @(posedge core_clk_in)
    begin
        if (tr.push)
            mem_reg[wr_ptr_reg] <= tr.push_data;
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else if (tr.clear)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (tr.push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (do_pop || (tr.push && full))
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (tr.push && !full && !do_pop)
                count_reg <= count_reg + 1'b1;
            else if (do_pop && !tr.push)
                count_reg <= count_reg - 1'b1;
        end
    end

endmodule // trace_store

// *** dv/adapter_model.sv ***
`timescale 1ns/1ps
module adapter_model
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // drive side
    input wire logic slow_in,
    input wire logic req_in,
    input wire logic irq_in,
    output logic ack_out,
    output logic zero_event_out
);
    logic [1:0] wait_reg;
    // ==========================================
    // take requested bytes, answer interrupts with an all-zero event byte
    always @(negedge clk_in)
    begin
        ack_out <= 1'b0;
        zero_event_out <= 1'b0;
        if (rst_in)
            wait_reg <= 2'h0;
        else if ((req_in || irq_in) && !ack_out && !zero_event_out)
        begin
            wait_reg <= wait_reg + 2'h1;
            if (!slow_in || wait_reg == 2'h3)
            begin
                ack_out <= req_in;
                zero_event_out <= irq_in && !req_in;
                wait_reg <= 2'h0;
            end
        end
    end
endmodule // adapter_model

// *** dv/disk_drive_status_reporting_test.sv ***
`timescale 1ns/1ps
module disk_drive_status_reporting_test;
    // ==========================================
    // signals
    logic core_clk_in, rst_in, fault_reset_cmd_in, return_track_zero_cmd_in, seek_cmd_in;
    logic head_sel_cmd_in, event_done_in, zero_event_in, send_identity_bit_in, send_trace_in;
    logic send_detail_in, auto_status_mode_in, fault_detect_in, track_lock_lost_in, on_track_in;
    logic trace_push_in, cart_tab_in, fixed_switch_in, panel_protect_switch_in, slow;
    logic spindle_speed_ok_in, spindle_stopped_in, stop_condition_in, heads_on_tracks_in;
    logic purge_done_in, drive_selected_in, rd_start_in, xfer_req_out, xfer_ack_in, irq_out;
    logic halt_out, write_inhibit_out, head_load_start_out, positioner_move_out;
    logic [7:0] seek_cyl_in, head_num_in, firmware_trace_code, rd_data_out, target_cyl_out, d;
    logic [2:0] rd_addr_in, xfer_addr_out;
    logic [1:0] cur_head_out;
    int err_total, n_checks, i;
    logic move_seen = 1'b0;
    logic load_seen = 1'b0;
    drive_status DUT (.*);
    adapter_model partner (.clk_in(core_clk_in), .rst_in(rst_in), .slow_in(slow),
        .req_in(xfer_req_out), .irq_in(irq_out), .ack_out(xfer_ack_in),
        .zero_event_out(zero_event_in));
    // ==========================================
    // tasks
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge core_clk_in) s = 1'b1;
        @(negedge core_clk_in) s = 1'b0;
        repeat (4) @(negedge core_clk_in);
    endtask
    task rd(input logic [2:0] a);
        @(negedge core_clk_in) {rd_start_in, rd_addr_in} = {1'b1, a};
        @(negedge core_clk_in) rd_start_in = 1'b0;
        @(negedge core_clk_in) d = rd_data_out;
    endtask
    task wt(input bit use_irq, input logic lvl);
        repeat (30) if ((use_irq ? irq_out : xfer_req_out) !== lvl) @(negedge core_clk_in);
        chk(use_irq ? irq_out : xfer_req_out, lvl);
    endtask
    task final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // clock, watchdog, tests
    initial
    begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    // one-cycle pulses are caught here so that the tests can look at them later
    always @(posedge core_clk_in)
    begin
        if (positioner_move_out === 1'b1) move_seen <= 1'b1;
        if (head_load_start_out === 1'b1) load_seen <= 1'b1;
    end
    initial
    begin
        #200000 err_total++;
        final_report;
    end
    initial
    begin
        {fault_reset_cmd_in, return_track_zero_cmd_in, seek_cmd_in, head_sel_cmd_in} = '0;
        {event_done_in, send_identity_bit_in, send_trace_in, send_detail_in} = '0;
        {fault_detect_in, track_lock_lost_in, on_track_in, trace_push_in, fixed_switch_in} = '0;
        {panel_protect_switch_in, spindle_stopped_in, rd_start_in, rd_addr_in, slow} = '0;
        {seek_cyl_in, head_num_in, firmware_trace_code, err_total, n_checks} = '0;
        {spindle_speed_ok_in, heads_on_tracks_in, purge_done_in, drive_selected_in} = '1;
        {cart_tab_in, stop_condition_in, auto_status_mode_in, rst_in} = '1;
        repeat (2) @(posedge core_clk_in);
        @(negedge core_clk_in) rst_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        rd(3'h7); chk(d & 8'hdf, 8'hd0);
        chk(cur_head_out, 2'h0);
        rd(3'h2); chk(d, 8'ha1);
        rd(3'h0); chk(d, {drive_status_pkg::ID_CODE_DEFAULT, 4'h1});
        pulse(on_track_in); rd(3'h7); chk(d & 8'h24, 8'h20);
        for (i = 0; i < 3; i++) begin firmware_trace_code = 8'h10 + 8'(i); pulse(trace_push_in); end
        for (i = 0; i < 4; i++) begin rd(3'h1); chk(d, i < 3 ? 8'h10 + 8'(i) : 8'h00); end
        for (i = 0; i < 20; i++) begin firmware_trace_code = 8'h40 + 8'(i); pulse(trace_push_in); end
        rd(3'h1); chk(d, 8'h44);
        pulse(fault_reset_cmd_in); rd(3'h1); chk(d, 8'h00);
        seek_cyl_in = 8'hce; pulse(seek_cmd_in); rd(3'h7); chk(d & 8'h24, 8'h24);
        chk({move_seen, positioner_move_out}, 2'h0);
        pulse(return_track_zero_cmd_in); rd(3'h7); chk(d & 8'h04, 8'h00);
        seek_cyl_in = 8'h20; pulse(seek_cmd_in); rd(3'h7); chk(d & 8'h24, 8'h00);
        chk(target_cyl_out, 8'h20); chk(move_seen, 1'b1);
        head_num_in = 8'h02; pulse(head_sel_cmd_in);
        rd(3'h7); chk({cur_head_out, d[6]}, 3'h4);
        fixed_switch_in = 1'b1; repeat (3) @(negedge core_clk_in);
        rd(3'h7); chk(d[6], 1'b1); rd(3'h2); chk(d, 8'ha3);
        head_num_in = 8'h04; pulse(head_sel_cmd_in); pulse(fault_reset_cmd_in);
        rd(3'h7); chk(d & 8'h04, 8'h04); chk(cur_head_out, 2'h2);
        pulse(return_track_zero_cmd_in); pulse(track_lock_lost_in);
        rd(3'h7); chk(d & 8'h24, 8'h04);
        pulse(return_track_zero_cmd_in); fault_detect_in = 1'b1; pulse(fault_reset_cmd_in);
        rd(3'h7); chk({d[0], halt_out, write_inhibit_out}, 3'h7);
        fault_detect_in = 1'b0; repeat (4) @(negedge core_clk_in);
        chk(load_seen, 1'b0);
        panel_protect_switch_in = 1'b1; repeat (6) @(negedge core_clk_in);
        rd(3'h7); chk(d & 8'h01, 8'h00); chk(load_seen, 1'b1);
        slow = 1'b1; pulse(event_done_in); wt(0, 1); chk(xfer_addr_out, 3'h7); wt(0, 0);
        pulse(send_identity_bit_in); wt(0, 1); chk(xfer_addr_out, 3'h0); wt(0, 0);
        @(negedge core_clk_in) {send_trace_in, send_detail_in, event_done_in} = '1;
        @(negedge core_clk_in) {send_trace_in, send_detail_in, event_done_in} = '0;
        wt(0, 1); chk(xfer_addr_out, 3'h1); wt(0, 0);
        wt(0, 1); chk(xfer_addr_out, 3'h2); wt(0, 0);
        wt(0, 1); chk(xfer_addr_out, 3'h7); wt(0, 0);
        auto_status_mode_in = 1'b0; pulse(event_done_in); wt(1, 1); wt(1, 0);
        {auto_status_mode_in, drive_selected_in} = 2'b10; wt(1, 1); wt(1, 0);
        pulse(on_track_in); wt(1, 1); wt(1, 0);
        final_report;
    end
endmodule // disk_drive_status_reporting_test
